// ---- hw/dspc_pkg.sv ----
// Types shared by the position compare block
package dspc_pkg;

  typedef enum logic [2:0] {PH_IDLE, PH_RES, PH_LOW, PH_HIGH, PH_PITCH, PH_RUN} dspc_phase_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dspc_wb_req_type;

  typedef struct packed {
    logic                en;
    logic                interp;
    logic [1:0]          wsel;
    logic [1:0]          ssel;
    logic signed [31:0]  low;
    logic signed [31:0]  high;
    logic signed [31:0]  pitch;
    logic [31:0]         cres;
    logic [31:0]         sper;
    logic [15:0]         imult;
    dspc_phase_type      ph;
    logic [31:0]         num;
    logic [31:0]         den;
    logic [32:0]         rem;
    logic [5:0]          dcnt;
    logic                neg;
    logic [31:0]         res;
    logic signed [31:0]  lo_c;
    logic signed [31:0]  hi_c;
    logic signed [31:0]  pit_c;
    logic signed [31:0]  last;
    logic signed [31:0]  pos;
    logic                fa;
    logic                fb;
    logic [11:0]         cnt_a;
    logic [11:0]         cnt_b;
    logic                inwin;
    logic                pulse;
    logic [11:0]         pcnt;
    logic                ack;
    logic [31:0]         rdat;
  } dspc_state_type;

endpackage

// ---- hw/dspc_regs.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef DSPC_REGS_SVH
`define DSPC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DSPC_OFF_CTRL      8'h00
`define DSPC_OFF_LOW       8'h04
`define DSPC_OFF_HIGH      8'h08
`define DSPC_OFF_PITCH     8'h0c
`define DSPC_OFF_CRES      8'h10
`define DSPC_OFF_SPER      8'h14
`define DSPC_OFF_IMULT     8'h18
`define DSPC_OFF_POS       8'h1c
`define DSPC_OFF_STATUS    8'h20

// ****************************************
// Control fields
// ****************************************
`define DSPC_CTRL_EN       0
`define DSPC_CTRL_INTERP   1
`define DSPC_CTRL_WSEL_LO  2
`define DSPC_CTRL_WSEL_HI  3
`define DSPC_CTRL_SSEL_LO  4
`define DSPC_CTRL_SSEL_HI  5

// ****************************************
// Reset values
// ****************************************
`define DSPC_RST_SEL       2'h0
`define DSPC_RST_CRES      32'h0000_0001
`define DSPC_RST_SPER      32'h0000_0001
`define DSPC_RST_IMULT     16'h0001

// ****************************************
// Timing: times in ns, cycles rounded up at 200 MHz
// ****************************************
`define DSPC_CLK_MHZ       200
`define DSPC_CYC(ns)       ((((ns) * `DSPC_CLK_MHZ) + 999) / 1000)
`define DSPC_SETTLE_0_NS   75
`define DSPC_SETTLE_1_NS   1000
`define DSPC_SETTLE_2_NS   4000
`define DSPC_SETTLE_3_NS   12000
`define DSPC_WIDTH_0_NS    200
`define DSPC_WIDTH_1_NS    1000
`define DSPC_WIDTH_2_NS    2500
`define DSPC_WIDTH_3_NS    10000
`define DSPC_DIV_STEPS     6'h20

`endif

// ---- hw/dspc_top.sv ----
// Distance spaced position compare trigger generator with Wishbone registers
`timescale 1ns/100ps
`default_nettype none
`include "dspc_regs.svh"

module dspc_top (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire dspc_pkg::dspc_wb_req_type wb_req_in,
  output logic [31:0]                   wb_dat_out,
  output logic                          wb_ack_out,
  input  wire logic                     enc_a_in,
  input  wire logic                     enc_b_in,
  output logic                          trigger_out,
  output logic                          window_out
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [11:0] settle_cycles(input logic [1:0] sel);
    logic [11:0] c;
    c = 12'(`DSPC_CYC(`DSPC_SETTLE_0_NS));
    unique case (sel)
      2'h0: c = 12'(`DSPC_CYC(`DSPC_SETTLE_0_NS));
      2'h1: c = 12'(`DSPC_CYC(`DSPC_SETTLE_1_NS));
      2'h2: c = 12'(`DSPC_CYC(`DSPC_SETTLE_2_NS));
      2'h3: c = 12'(`DSPC_CYC(`DSPC_SETTLE_3_NS));
    endcase
    return c;
  endfunction

  function automatic logic [11:0] width_cycles(input logic [1:0] sel);
    logic [11:0] c;
    c = 12'(`DSPC_CYC(`DSPC_WIDTH_0_NS));
    unique case (sel)
      2'h0: c = 12'(`DSPC_CYC(`DSPC_WIDTH_0_NS));
      2'h1: c = 12'(`DSPC_CYC(`DSPC_WIDTH_1_NS));
      2'h2: c = 12'(`DSPC_CYC(`DSPC_WIDTH_2_NS));
      2'h3: c = 12'(`DSPC_CYC(`DSPC_WIDTH_3_NS));
    endcase
    return c;
  endfunction

  // Byte-lane merge of a Wishbone write into a 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Magnitude plus half a resolution, so truncating division rounds to nearest
  function automatic logic [31:0] round_num(input logic signed [31:0] x, input logic [31:0] res);
    logic [31:0] mag;
    mag = x[31] ? 32'(-x) : 32'(x);
    return mag + (res >> 1);
  endfunction

  function automatic logic [31:0] at_least_one(input logic [31:0] q);
    return (q == 32'h0) ? 32'h1 : q;
  endfunction

  // ****************************************
  // State
  // ****************************************
  dspc_pkg::dspc_state_type s_r;
  dspc_pkg::dspc_state_type s_nxt;

  always_comb begin
    logic        acc;
    logic        wr;
    logic [31:0] q;
    logic [31:0] rq;
    logic [32:0] tr;
    logic        a_new;
    logic        b_new;
    logic        inw;
    logic        trig;
    logic [31:0] ctl;
    acc = 1'b0;
    wr = 1'b0;
    q = 32'h0;
    rq = 32'h0;
    tr = 33'h0;
    a_new = 1'b0;
    b_new = 1'b0;
    inw = 1'b0;
    trig = 1'b0;
    ctl = 32'h0;
    s_nxt = s_r;

    // ****************************************
    // Wishbone slave: ack one cycle after the strobe, drops next cycle
    // ****************************************
    acc = wb_req_in.cyc && wb_req_in.stb && !s_r.ack;
    wr = acc && wb_req_in.we;
    s_nxt.ack = acc;
    ctl = {26'h0, s_r.ssel, s_r.wsel, s_r.interp, s_r.en};
    if (acc && !wb_req_in.we) begin
      unique case (wb_req_in.adr)
        `DSPC_OFF_CTRL:   s_nxt.rdat = ctl;
        `DSPC_OFF_LOW:    s_nxt.rdat = s_r.low;
        `DSPC_OFF_HIGH:   s_nxt.rdat = s_r.high;
        `DSPC_OFF_PITCH:  s_nxt.rdat = s_r.pitch;
        `DSPC_OFF_CRES:   s_nxt.rdat = s_r.cres;
        `DSPC_OFF_SPER:   s_nxt.rdat = s_r.sper;
        `DSPC_OFF_IMULT:  s_nxt.rdat = {16'h0, s_r.imult};
        `DSPC_OFF_POS:    s_nxt.rdat = s_r.pos;
        `DSPC_OFF_STATUS: s_nxt.rdat = {29'h0, s_r.pulse, s_r.inwin, s_r.ph == dspc_pkg::PH_RUN};
        default:          s_nxt.rdat = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (wb_req_in.adr)
        `DSPC_OFF_CTRL: begin
          ctl = merge(ctl, wb_req_in.dat, wb_req_in.sel);
          s_nxt.en = ctl[`DSPC_CTRL_EN];
          s_nxt.interp = ctl[`DSPC_CTRL_INTERP];
          s_nxt.wsel = ctl[`DSPC_CTRL_WSEL_HI:`DSPC_CTRL_WSEL_LO];
          s_nxt.ssel = ctl[`DSPC_CTRL_SSEL_HI:`DSPC_CTRL_SSEL_LO];
        end
        `DSPC_OFF_LOW:   s_nxt.low = merge(s_r.low, wb_req_in.dat, wb_req_in.sel);
        `DSPC_OFF_HIGH:  s_nxt.high = merge(s_r.high, wb_req_in.dat, wb_req_in.sel);
        `DSPC_OFF_PITCH: s_nxt.pitch = merge(s_r.pitch, wb_req_in.dat, wb_req_in.sel);
        `DSPC_OFF_CRES:  s_nxt.cres = merge(s_r.cres, wb_req_in.dat, wb_req_in.sel);
        `DSPC_OFF_SPER:  s_nxt.sper = merge(s_r.sper, wb_req_in.dat, wb_req_in.sel);
        `DSPC_OFF_IMULT: s_nxt.imult = 16'(merge({16'h0, s_r.imult}, wb_req_in.dat, wb_req_in.sel));
        `DSPC_OFF_POS:   s_nxt.pos = merge(s_r.pos, wb_req_in.dat, wb_req_in.sel);
        default: begin
        end
      endcase
    end

    // ****************************************
    // Settle filter and quadrature decode
    // ****************************************
    // A level is accepted only after it has held for the whole settle time,
    // which is also the nominal delay from encoder edge to trigger
    a_new = s_r.fa;
    b_new = s_r.fb;
    if (enc_a_in == s_r.fa) begin
      s_nxt.cnt_a = 12'h0;
    end else if (s_r.cnt_a + 12'h1 >= settle_cycles(s_r.ssel)) begin
      s_nxt.cnt_a = 12'h0;
      a_new = enc_a_in;
    end else begin
      s_nxt.cnt_a = s_r.cnt_a + 12'h1;
    end
    if (enc_b_in == s_r.fb) begin
      s_nxt.cnt_b = 12'h0;
    end else if (s_r.cnt_b + 12'h1 >= settle_cycles(s_r.ssel)) begin
      s_nxt.cnt_b = 12'h0;
      b_new = enc_b_in;
    end else begin
      s_nxt.cnt_b = s_r.cnt_b + 12'h1;
    end
    s_nxt.fa = a_new;
    s_nxt.fb = b_new;
    // Both channels moving at once is a lost step; it is dropped, not guessed
    if ((a_new != s_r.fa) ^ (b_new != s_r.fb)) begin
      if (s_r.fa ^ b_new) begin
        s_nxt.pos = s_r.pos + 32'sh1;
      end else begin
        s_nxt.pos = s_r.pos - 32'sh1;
      end
    end

    // ****************************************
    // Rounding sequence: serial divider shared by all four quotients
    // ****************************************
    if (s_r.dcnt != 6'h0) begin
      tr = {s_r.rem[31:0], s_r.num[31]};
      s_nxt.num = {s_r.num[30:0], 1'b0};
      if (tr >= {1'b0, s_r.den}) begin
        tr = tr - {1'b0, s_r.den};
        s_nxt.num[0] = 1'b1;
      end
      s_nxt.rem = tr;
      s_nxt.dcnt = s_r.dcnt - 6'h1;
    end
    q = s_r.num;
    rq = at_least_one(q);
    unique case (s_r.ph)
      dspc_pkg::PH_IDLE: begin
        if (s_r.en) begin
          s_nxt.ph = dspc_pkg::PH_RES;
          s_nxt.num = s_r.interp ? s_r.sper : s_r.cres;
          s_nxt.den = s_r.interp ? at_least_one({16'h0, s_r.imult}) : 32'h1;
          s_nxt.rem = 33'h0;
          s_nxt.dcnt = `DSPC_DIV_STEPS;
        end
      end
      dspc_pkg::PH_RES: begin
        if (s_r.dcnt == 6'h0) begin
          s_nxt.res = rq;
          s_nxt.ph = dspc_pkg::PH_LOW;
          s_nxt.neg = s_r.low[31];
          s_nxt.num = round_num(s_r.low, rq);
          s_nxt.den = rq;
          s_nxt.rem = 33'h0;
          s_nxt.dcnt = `DSPC_DIV_STEPS;
        end
      end
      dspc_pkg::PH_LOW: begin
        if (s_r.dcnt == 6'h0) begin
          s_nxt.lo_c = s_r.neg ? 32'(-q) : q;
          s_nxt.ph = dspc_pkg::PH_HIGH;
          s_nxt.neg = s_r.high[31];
          s_nxt.num = round_num(s_r.high, s_r.res);
          s_nxt.den = s_r.res;
          s_nxt.rem = 33'h0;
          s_nxt.dcnt = `DSPC_DIV_STEPS;
        end
      end
      dspc_pkg::PH_HIGH: begin
        if (s_r.dcnt == 6'h0) begin
          s_nxt.hi_c = s_r.neg ? 32'(-q) : q;
          s_nxt.ph = dspc_pkg::PH_PITCH;
          s_nxt.num = round_num(s_r.pitch, s_r.res);
          s_nxt.den = s_r.res;
          s_nxt.rem = 33'h0;
          s_nxt.dcnt = `DSPC_DIV_STEPS;
        end
      end
      dspc_pkg::PH_PITCH: begin
        if (s_r.dcnt == 6'h0) begin
          s_nxt.pit_c = rq;
          s_nxt.ph = dspc_pkg::PH_RUN;
        end
      end
      dspc_pkg::PH_RUN: begin
        // Inclusive bounds; the step compare is equality since the count moves by one
        inw = (s_r.pos >= s_r.lo_c) && (s_r.pos <= s_r.hi_c);
        if (inw && !s_r.inwin) begin
          trig = 1'b1;
          s_nxt.last = s_r.pos;
        end else if (inw && ((s_r.pos == s_r.last + s_r.pit_c) || (s_r.pos == s_r.last - s_r.pit_c))) begin
          trig = 1'b1;
          s_nxt.last = s_r.pos;
        end
      end
    endcase
    // Turning compare off drops straight back to idle, mid-sequence included
    if (!s_nxt.en) begin
      s_nxt.ph = dspc_pkg::PH_IDLE;
      s_nxt.dcnt = 6'h0;
    end
    s_nxt.inwin = inw && s_nxt.en;

    // ****************************************
    // Trigger pulse: width counted from the event, so the fall is exact
    // ****************************************
    if (trig) begin
      s_nxt.pulse = 1'b1;
      s_nxt.pcnt = width_cycles(s_r.wsel);
    end else if (s_r.pcnt > 12'h1) begin
      s_nxt.pcnt = s_r.pcnt - 12'h1;
    end else begin
      s_nxt.pcnt = 12'h0;
      s_nxt.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_r <= '0;
      s_r.wsel <= `DSPC_RST_SEL;
      s_r.ssel <= `DSPC_RST_SEL;
      s_r.cres <= `DSPC_RST_CRES;
      s_r.sper <= `DSPC_RST_SPER;
      s_r.imult <= `DSPC_RST_IMULT;
      s_r.res <= `DSPC_RST_CRES;
      s_r.pit_c <= `DSPC_RST_CRES;
      s_r.ph <= dspc_pkg::PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_out = s_r.rdat;
  assign wb_ack_out = s_r.ack;
  assign trigger_out = s_r.pulse;
  assign window_out = s_r.inwin;

endmodule

`default_nettype wire

// ---- sim/dspc_checker.sv ----
// Assertion checker for the position compare block
`timescale 1ns/100ps
`default_nettype none
module dspc_checker (
  input wire logic                      clk_in,
  input wire logic                      resetn_in,
  input wire dspc_pkg::dspc_wb_req_type wb_req_in,
  input wire logic [31:0]               wb_dat_out,
  input wire logic                      wb_ack_out,
  input wire logic                      trigger_out,
  input wire logic                      window_out
);
  logic        take;
  logic        trig_q;
  logic [1:0]  wsel_q;
  logic [1:0]  wsel_r;
  logic [5:0]  ctrl_r;
  logic [11:0] hcnt_r;
  logic [11:0] wcyc;
  assign take = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  assign wcyc = (wsel_r == 2'h0) ? 12'h028 : (wsel_r == 2'h1) ? 12'h0c8 :
                (wsel_r == 2'h2) ? 12'h1f4 : 12'h7d0;
  // Shadow of the control bits; a pulse keeps the width select seen when it was launched,
  // so a reconfiguration during a pulse must not retime it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_r <= 6'h00;
      hcnt_r <= 12'h000;
      trig_q <= 1'b0;
      wsel_q <= 2'h0;
      wsel_r <= 2'h0;
    end else begin
      if (take && wb_req_in.we && wb_req_in.adr == 8'h00 && wb_req_in.sel[0]) begin
        ctrl_r <= wb_req_in.dat[5:0];
      end
      trig_q <= trigger_out;
      wsel_q <= ctrl_r[3:2];
      if (trigger_out && !trig_q) begin
        wsel_r <= wsel_q;
      end
      hcnt_r <= trigger_out ? hcnt_r + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence take_s; take; endsequence
  sequence ack_s; wb_ack_out ##1 !wb_ack_out; endsequence
  ack_latency_a: assert property (take_s |=> ack_s)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_req_in.cyc && wb_req_in.stb))
    else $error("ack without request");
  ctrl_readback_a: assert property (wb_ack_out && !wb_req_in.we && wb_req_in.adr == 8'h00 |->
    wb_dat_out[5:0] == ctrl_r) else $error("control readback differs");
  unmapped_zero_a: assert property (wb_ack_out && !wb_req_in.we && wb_req_in.adr > 8'h20 |->
    wb_dat_out == 32'h0) else $error("unmapped read not zero");
  pulse_width_a: assert property ($fell(trigger_out) |-> hcnt_r == wcyc)
    else $error("trigger width wrong");
  first_pulse_a: assert property ($rose(window_out) |-> $rose(trigger_out))
    else $error("window entry without pulse");
  inside_only_a: assert property ($rose(trigger_out) |-> window_out)
    else $error("pulse outside window");
  off_window_a: assert property (!ctrl_r[0] |=> !window_out)
    else $error("window high while disabled");
endmodule
bind dspc_top dspc_checker dspc_checker_inst (
  .clk_in     (clk_in),
  .resetn_in  (resetn_in),
  .wb_req_in  (wb_req_in),
  .wb_dat_out (wb_dat_out),
  .wb_ack_out (wb_ack_out),
  .trigger_out(trigger_out),
  .window_out (window_out)
);
`default_nettype wire

// ---- sim/dspc_enc_model.sv ----
// Quadrature encoder model driving the block's encoder pins
`timescale 1ns/100ps
`default_nettype none
module dspc_enc_model (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic up_in,
  input  wire logic glitch_in,
  output logic      enc_a_out,
  output logic      enc_b_out
);
  logic [1:0] q_r = 2'h0;
  // Gray order 00,01,11,10 counts up; one channel moves per step
  // Steps never come faster than the bench period, which exceeds the settle time
  always @(posedge clk_in) begin
    if (step_in) begin
      q_r <= up_in ? q_r + 2'h1 : q_r - 2'h1;
    end
  end
  // A flip shorter than the settle time models jitter the filter must hide
  assign enc_a_out = q_r[1] ^ glitch_in;
  assign enc_b_out = q_r[1] ^ q_r[0];
endmodule
`default_nettype wire

// ---- sim/dspc_top_test.sv ----
// Self-checking bench for the position compare block
`timescale 1ns/100ps
`default_nettype none
module dspc_top_test;
  logic                      clk_in = 1'b0;
  logic                      resetn_in = 1'b0;
  dspc_pkg::dspc_wb_req_type wb_r = '0;
  logic [31:0]               wb_dat, rd;
  logic                      wb_ack, enc_a, enc_b, trig, win;
  logic                      step_r = 1'b0, up_r = 1'b1, glitch_r = 1'b0, trig_d = 1'b0, en_b = 1'b0;
  int                        n_mismatch = 0, cmp_count = 0, cyc_n = 0, n_trig = 0;
  int                        last_step = 0, pos = 0, settle = 15;
  always #2.5 clk_in = ~clk_in;
  dspc_top dspc_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .wb_req_in(wb_r), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .enc_a_in(enc_a), .enc_b_in(enc_b), .trigger_out(trig), .window_out(win));
  dspc_enc_model dspc_enc_model_inst (.clk_in(clk_in), .step_in(step_r), .up_in(up_r),
    .glitch_in(glitch_r), .enc_a_out(enc_a), .enc_b_out(enc_b));
  // ****
  // Helpers
  // ****
  function automatic int settle_cyc(input logic [1:0] s);
    return (s == 2'h0) ? 15 : (s == 2'h1) ? 200 : (s == 2'h2) ? 800 : 2400;
  endfunction
  function automatic int width_cyc(input logic [1:0] w);
    return (w == 2'h0) ? 40 : (w == 2'h1) ? 200 : (w == 2'h2) ? 500 : 2000;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Request held until ack is sampled high, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat;
    wb_r <= '0;
    @(posedge clk_in);
    check("bus ack", 32'h1, {31'h0, n < 50});
  endtask
  task automatic move(input logic up, input int n, input int period);
    repeat (n) begin
      up_r <= up;
      step_r <= 1'b1;
      last_step = cyc_n;
      @(posedge clk_in);
      step_r <= 1'b0;
      pos = up ? pos + 1 : pos - 1;
      repeat (period - 1) @(posedge clk_in);
      check("window", {31'h0, en_b && pos >= 4 && pos <= 12}, {31'h0, win});
    end
  endtask
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    trig_d <= trig;
    if (trig === 1'b1 && trig_d === 1'b0) begin
      n_trig++;
      check("delay", 32'h1, {31'h0, cyc_n - last_step >= settle && cyc_n - last_step <= settle + 6});
    end
    if (cyc_n == 105000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    logic [1:0]  s, ws;
    logic        it;
    int          r, m, period, t0;
    logic [31:0] cfg [3];
    void'($urandom(88));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    wb(1'b0, 8'h00, 32'h0); check("ctrl reset", 32'h0, rd);
    wb(1'b0, 8'h10, 32'h0); check("cres reset", 32'h1, rd);
    wb(1'b0, 8'h24, 32'h0); check("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      ws = i[1:0];
      s = 2'h3 - ws;
      settle = settle_cyc(s);
      period = ((width_cyc(ws) / 2 > settle + 25) ? width_cyc(ws) / 2 : settle + 25) + 20;
      r = 1 + $urandom % 8;
      m = 1 + $urandom % 4;
      it = $urandom % 2;
      // Offsets below half a resolution step must round away
      cfg[0] = 4 * r + $urandom % ((r + 1) / 2);
      cfg[1] = 12 * r + $urandom % ((r + 1) / 2);
      cfg[2] = 4 * r - $urandom % ((r + 1) / 2);
      wb(1'b1, 8'h10, r);
      wb(1'b1, 8'h14, r * m);
      wb(1'b1, 8'h18, m);
      for (int k = 0; k < 3; k++) wb(1'b1, 8'h04 + 8'(4 * k), cfg[k]);
      wb(1'b1, 8'h1c, 32'h3);
      pos = 3;
      wb(1'b1, 8'h00, {26'h0, s, ws, it, 1'b1});
      en_b = 1'b1;
      t0 = 0;
      do begin
        wb(1'b0, 8'h20, 32'h0);
        t0++;
      end while (rd[0] !== 1'b1 && t0 < 100);
      check("running", 32'h1, {31'h0, rd[0]});
      for (int k = 0; k < 3; k++) begin
        wb(1'b0, 8'h04 + 8'(4 * k), 32'h0);
        check("readback", cfg[k], rd);
      end
      glitch_r <= 1'b1;
      repeat (settle / 2) @(posedge clk_in);
      glitch_r <= 1'b0;
      n_trig = 0;
      move(1'b1, 10, period); check("pulses up", 32'h3, n_trig);
      move(1'b0, 10, period); check("pulses down", 32'h6, n_trig);
      wb(1'b0, 8'h1c, 32'h0); check("position", 32'h3, rd);
      wb(1'b1, 8'h00, {26'h0, s, ws, it, 1'b0});
      en_b = 1'b0;
    end
    // Disable inside the window: window drops and no further pulse
    // Shortest settle and width, so the step period may stay short
    settle = settle_cyc(2'h0);
    wb(1'b1, 8'h00, 32'h01);
    en_b = 1'b1;
    repeat (200) @(posedge clk_in);
    n_trig = 0;
    move(1'b1, 2, 60); check("pulses on", 32'h1, n_trig);
    wb(1'b1, 8'h00, 32'h00);
    en_b = 1'b0;
    n_trig = 0;
    move(1'b1, 4, 60); check("pulses off", 32'h0, n_trig);
    end_of_test();
  end
endmodule
`default_nettype wire
